// File: pkg/scr_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the system control registers
// Assumes: Byte addressed register access, low byte at the even address
// Notes: Millisecond cycle counts derive from the 125 MHz system clock; the boot count is a fixed 64 cycles
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

`define SCR_CLK_KHZ 125000
`define SCR_OFF_FLASH_WRITE_COUNTER 7'h00
`define SCR_OFF_MISC 7'h38
`define SCR_OFF_SLEEP 7'h3e
`define SCR_OFF_DIAG 7'h40
`define SCR_OFF_GCMD 7'h42
`define SCR_OFF_LOT1 7'h52
`define SCR_OFF_LOT2 7'h54
`define SCR_OFF_PROD 7'h56
`define SCR_OFF_SERIAL 7'h58

`define SCR_GCMD_RESET 7
`define SCR_GCMD_FLASH 3
`define SCR_GCMD_DAC 2
`define SCR_GCMD_CAL 1
`define SCR_GCMD_BIAS 0
`define SCR_SLEEP_UNTIMED 0
`define SCR_MISC_CHKSUM 11
`define SCR_MISC_SELFTEST 10
`define SCR_MISC_LIN_COMP 7
`define SCR_MISC_PERCUSSION 6
`define SCR_MISC_DRDY_EN 2
`define SCR_MISC_DRDY_POL 1
`define SCR_MISC_DRDY_LINE 0
`define SCR_MISC_WMASK 8'hc7
`define SCR_MISC_RESET 16'h0006
`define SCR_DIAG_CHKSUM 6
`define SCR_DIAG_SELFTEST 5
`define SCR_DIAG_AXIS_LO 10
`define SCR_SERIAL_MASK 16'h0fff

`define SCR_FLASH_MS 75
`define SCR_CHKSUM_MS 20
`define SCR_SELFTEST_MS 10
`define SCR_SLEEP_UNIT_MS 500
`define SCR_BOOT_CYCLES 64
`define SCR_FLASH_CYCLES (`SCR_FLASH_MS * `SCR_CLK_KHZ)
`define SCR_CHKSUM_CYCLES (`SCR_CHKSUM_MS * `SCR_CLK_KHZ)
`define SCR_SELFTEST_CYCLES (`SCR_SELFTEST_MS * `SCR_CLK_KHZ)
`define SCR_SLEEP_UNIT_CYCLES (`SCR_SLEEP_UNIT_MS * `SCR_CLK_KHZ)

`endif

// File: pkg/scr_pkg.sv
// Purpose: Types shared by the system control register block
// Assumes: Constants come from scr_consts.svh
// Notes: One-hot sequencer states
package scr_pkg;

  typedef enum logic [5:0] {
    SCR_IDLE = 6'b000001,
    SCR_BOOT = 6'b000010,
    SCR_FLASH = 6'b000100,
    SCR_CHKSUM = 6'b001000,
    SCR_SELFTEST = 6'b010000,
    SCR_SLEEP = 6'b100000
  } scr_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } scr_req_t;

  typedef struct packed {
    logic checksum_ok;
    logic [5:0] axis_fail;
  } scr_sense_t;

  typedef struct packed {
    scr_state_t fsm;
    logic [31:0] timer;
    logic [7:0] sleep_units;
    logic sleep_untimed;
    logic [7:0] gcmd;
    logic [7:0] flash_src;
    logic [15:0] misc;
    logic [15:0] nv_misc;
    logic [15:0] flash_write_counter;
    logic [15:0] diag;
    logic [7:0] rdata;
    logic halt;
    logic reload;
    logic dac_latch;
    logic cal_restore;
    logic bias_corr;
    logic asleep;
    logic flash_busy;
    logic chksum_busy;
    logic selftest_busy;
    logic [2:0] cs_sync;
    logic [2:0] rstp_sync;
    logic cs_lvl;
    logic rstp_lvl;
  } scr_st_t;

endpackage

// File: verilog/scr_regs.sv
// Purpose: System control registers: commands, sleep, identity, flash count, tests
// Assumes: Byte wide register port fed by an SPI front end on sys_clk
// Notes: Contract
`timescale 1ns/1ps
`include "scr_consts.svh"

module scr_regs #(
  parameter logic [31:0] FLASH_CYCLES = `SCR_FLASH_CYCLES,
  parameter logic [31:0] CHKSUM_CYCLES = `SCR_CHKSUM_CYCLES,
  parameter logic [31:0] SELFTEST_CYCLES = `SCR_SELFTEST_CYCLES,
  parameter logic [31:0] SLEEP_UNIT_CYCLES = `SCR_SLEEP_UNIT_CYCLES,
  parameter logic [31:0] BOOT_CYCLES = `SCR_BOOT_CYCLES,
  parameter logic [31:0] LOT_CODE = 32'h1234_5678,
  parameter logic [15:0] PRODUCT_CODE = 16'h0a5a,
  parameter logic [15:0] SERIAL_CODE = 16'h0001
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scr_pkg::scr_req_t req,
  input wire scr_pkg::scr_sense_t sense,
  input wire logic cs_n,
  input wire logic rst_pin_n,
  output logic [7:0] rdata,
  output logic halt,
  output logic reload,
  output logic dac_latch,
  output logic cal_restore,
  output logic bias_corr,
  output logic asleep,
  output logic flash_busy,
  output logic chksum_busy,
  output logic selftest_busy,
  output logic lin_comp_en,
  output logic percussion_en,
  output logic drdy_en,
  output logic drdy_active_high,
  output logic drdy_line_two
);
  import scr_pkg::*;

  scr_st_t q;
  scr_st_t n;
  logic [15:0] rd_word;
  logic cs_fall;
  logic rstp_fall;
  logic wake;

  // Identity and status read decode, word then byte lane
  always_comb begin
    unique case ({req.addr[6:1], 1'b0})
      `SCR_OFF_FLASH_WRITE_COUNTER: rd_word = q.flash_write_counter;
      `SCR_OFF_MISC: rd_word = q.misc;
      `SCR_OFF_DIAG: rd_word = q.diag;
      `SCR_OFF_LOT1: rd_word = LOT_CODE[15:0];
      `SCR_OFF_LOT2: rd_word = LOT_CODE[31:16];
      `SCR_OFF_PROD: rd_word = PRODUCT_CODE;
      `SCR_OFF_SERIAL: rd_word = SERIAL_CODE & `SCR_SERIAL_MASK;
      default: rd_word = 16'h0000;
    endcase
  end

  // Wake edges after the three stage synchronisers
  assign cs_fall = q.cs_lvl & ~q.cs_sync[1] & ~q.cs_sync[2];
  assign rstp_fall = q.rstp_lvl & ~q.rstp_sync[1] & ~q.rstp_sync[2];
  assign wake = cs_fall | rstp_fall;

  always_comb begin
    n = q;
    n.reload = 1'b0;
    n.dac_latch = 1'b0;
    n.cal_restore = 1'b0;
    n.bias_corr = 1'b0;
    n.cs_sync = {q.cs_sync[1:0], cs_n};
    n.rstp_sync = {q.rstp_sync[1:0], rst_pin_n};
    if (q.cs_sync[1] == q.cs_sync[2]) begin
      n.cs_lvl = q.cs_sync[2];
    end
    if (q.rstp_sync[1] == q.rstp_sync[2]) begin
      n.rstp_lvl = q.rstp_sync[2];
    end

    // Register reads, low byte at the even address
    if (req.rd) begin
      n.rdata = req.addr[0] ? rd_word[15:8] : rd_word[7:0];
      if (req.addr == (`SCR_OFF_DIAG | 7'h01)) begin
        n.diag = 16'h0000;
      end
    end

    // Register writes, one byte per access
    if (req.wr) begin
      unique case (req.addr)
        `SCR_OFF_MISC: begin
          n.misc[7:0] = req.wdata & `SCR_MISC_WMASK;
        end
        (`SCR_OFF_MISC | 7'h01): begin
          n.misc[15:8] = q.misc[15:8] | (req.wdata & 8'h0c);
        end
        `SCR_OFF_SLEEP: begin
          n.sleep_units = req.wdata;
        end
        (`SCR_OFF_SLEEP | 7'h01): begin
          n.sleep_untimed = q.sleep_untimed | req.wdata[`SCR_SLEEP_UNTIMED];
        end
        `SCR_OFF_GCMD: begin
          n.gcmd = q.gcmd | (req.wdata & 8'h8f);
        end
        default: begin
        end
      endcase
    end

    if (q.timer != 32'h0) begin
      n.timer = q.timer - 32'h1;
    end

    unique case (q.fsm)
      SCR_IDLE: begin
        if (q.gcmd[`SCR_GCMD_RESET]) begin
          n.fsm = SCR_BOOT;
          n.halt = 1'b1;
          n.reload = 1'b1;
          n.misc = q.nv_misc;
          n.timer = BOOT_CYCLES;
        end else if (q.gcmd[`SCR_GCMD_FLASH]) begin
          n.fsm = SCR_FLASH;
          n.flash_busy = 1'b1;
          n.flash_src = 8'h08;
          n.timer = FLASH_CYCLES;
        end else if (q.gcmd[`SCR_GCMD_CAL]) begin
          n.cal_restore = 1'b1;
          n.fsm = SCR_FLASH;
          n.flash_busy = 1'b1;
          n.flash_src = 8'h02;
          n.timer = FLASH_CYCLES;
        end else if (q.gcmd[`SCR_GCMD_BIAS]) begin
          n.bias_corr = 1'b1;
          n.fsm = SCR_FLASH;
          n.flash_busy = 1'b1;
          n.flash_src = 8'h01;
          n.timer = FLASH_CYCLES;
        end else if (q.gcmd[`SCR_GCMD_DAC]) begin
          n.dac_latch = 1'b1;
          n.gcmd[`SCR_GCMD_DAC] = 1'b0;
        end else if (q.misc[`SCR_MISC_CHKSUM]) begin
          n.fsm = SCR_CHKSUM;
          n.chksum_busy = 1'b1;
          n.timer = CHKSUM_CYCLES;
        end else if (q.misc[`SCR_MISC_SELFTEST]) begin
          n.fsm = SCR_SELFTEST;
          n.selftest_busy = 1'b1;
          n.timer = SELFTEST_CYCLES;
        end else if (q.sleep_untimed || q.sleep_units != 8'h00) begin
          n.fsm = SCR_SLEEP;
          n.asleep = 1'b1;
          n.timer = SLEEP_UNIT_CYCLES;
        end
      end
      SCR_BOOT: begin
        if (q.timer == 32'h1) begin
          n.fsm = SCR_IDLE;
          n.halt = 1'b0;
          n.gcmd = 8'h00;
          n.sleep_units = 8'h00;
          n.sleep_untimed = 1'b0;
        end
      end
      SCR_FLASH: begin
        if (q.timer == 32'h1) begin
          n.fsm = SCR_IDLE;
          n.flash_busy = 1'b0;
          n.nv_misc = q.misc & ~16'h0c00;
          n.flash_write_counter = q.flash_write_counter + 16'h1;
          n.gcmd = n.gcmd & ~q.flash_src;
        end
      end
      SCR_CHKSUM: begin
        if (q.timer == 32'h1) begin
          n.fsm = SCR_IDLE;
          n.chksum_busy = 1'b0;
          n.misc[`SCR_MISC_CHKSUM] = 1'b0;
          if (!sense.checksum_ok) begin
            n.diag[`SCR_DIAG_CHKSUM] = 1'b1;
          end
        end
      end
      SCR_SELFTEST: begin
        if (q.timer == 32'h1) begin
          n.fsm = SCR_IDLE;
          n.selftest_busy = 1'b0;
          n.misc[`SCR_MISC_SELFTEST] = 1'b0;
          if (|sense.axis_fail) begin
            n.diag[`SCR_DIAG_SELFTEST] = 1'b1;
            n.diag[15:`SCR_DIAG_AXIS_LO] = n.diag[15:`SCR_DIAG_AXIS_LO] | sense.axis_fail;
          end
        end
      end
      SCR_SLEEP: begin
        if (wake) begin
          n.fsm = SCR_IDLE;
          n.asleep = 1'b0;
          n.sleep_units = 8'h00;
          n.sleep_untimed = 1'b0;
          n.timer = 32'h0;
        end else if (!q.sleep_untimed && q.timer == 32'h1) begin
          if (q.sleep_units == 8'h01) begin
            n.fsm = SCR_IDLE;
            n.asleep = 1'b0;
            n.sleep_units = 8'h00;
          end else begin
            n.sleep_units = q.sleep_units - 8'h01;
            n.timer = SLEEP_UNIT_CYCLES;
          end
        end
      end
      default: begin
        n.fsm = SCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.fsm <= SCR_BOOT;
      q.timer <= BOOT_CYCLES;
      q.halt <= 1'b1;
      q.reload <= 1'b1;
      q.misc <= `SCR_MISC_RESET;
      q.nv_misc <= `SCR_MISC_RESET;
      q.cs_sync <= 3'b111;
      q.rstp_sync <= 3'b111;
      q.cs_lvl <= 1'b1;
      q.rstp_lvl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign rdata = q.rdata;
  assign halt = q.halt;
  assign reload = q.reload;
  assign dac_latch = q.dac_latch;
  assign cal_restore = q.cal_restore;
  assign bias_corr = q.bias_corr;
  assign asleep = q.asleep;
  assign flash_busy = q.flash_busy;
  assign chksum_busy = q.chksum_busy;
  assign selftest_busy = q.selftest_busy;
  assign lin_comp_en = q.misc[`SCR_MISC_LIN_COMP];
  assign percussion_en = q.misc[`SCR_MISC_PERCUSSION];
  assign drdy_en = q.misc[`SCR_MISC_DRDY_EN];
  assign drdy_active_high = q.misc[`SCR_MISC_DRDY_POL];
  assign drdy_line_two = q.misc[`SCR_MISC_DRDY_LINE];

endmodule

// File: verification/scr_regs_props.sv
// Purpose: Port checks for scr_regs
// Assumes: Shortened counts of the bench
// Notes: Bound to scr_regs
`timescale 1ns/1ps
module scr_regs_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scr_pkg::scr_req_t req,
  input wire logic cs_n,
  input wire logic [7:0] rdata,
  input wire logic halt,
  input wire logic dac_latch,
  input wire logic cal_restore,
  input wire logic bias_corr,
  input wire logic asleep,
  input wire logic flash_busy,
  input wire logic chksum_busy
);
  import scr_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  chk_boot_len: assert property ($rose(halt) |-> halt[*6] ##[1:3] !halt)
    else $error("halt length wrong");
  chk_halt_idle: assert property (halt |-> !flash_busy && !chksum_busy)
    else $error("busy while halted");
  chk_cmd_read: assert property (req.rd && req.addr[6:1] == 6'h21 |=> rdata == 8'h00)
    else $error("command reads nonzero");
  chk_dac_pulse: assert property (dac_latch |=> !dac_latch)
    else $error("dac latch too long");
  chk_cal_flash: assert property (cal_restore |-> ##[0:2] flash_busy)
    else $error("restore without flash");
  chk_bias_flash: assert property (bias_corr |-> ##[0:2] flash_busy)
    else $error("bias without flash");
  chk_sum_time: assert property ($rose(chksum_busy) |-> ##[1:60] !chksum_busy)
    else $error("checksum too long");
  chk_wake_cs: assert property (asleep && $fell(cs_n) |-> ##[1:8] !asleep)
    else $error("no wake on select");
  cover property (cal_restore);
  cover property (asleep ##1 !asleep);
  cover property ($fell(chksum_busy));
endmodule
bind scr_regs scr_regs_props scr_regs_props_i (.sys_clk, .rst, .req, .cs_n, .rdata, .halt,
  .dac_latch, .cal_restore, .bias_corr, .asleep, .flash_busy, .chksum_busy);

// File: verification/scr_host.sv
// Purpose: Host model, byte register access and select pin
// Assumes: Requests change 1 ns after the edge
// Notes: Tasks are called by the bench
`timescale 1ns/1ps
module scr_host (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output scr_pkg::scr_req_t req,
  output logic cs_n
);
  import scr_pkg::*;
  initial begin
    req = '0;
    cs_n = 1'b1;
  end
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    req.wr = 1'b0;
  endtask
  task automatic rd8(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge sys_clk);
    #1;
    req.rd = 1'b0;
    d = rdata;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    if (a == 7'h38) d[9:8] = 2'b00;
    wr8(a, d[7:0]);
    wr8(a + 7'h1, d[15:8]);
  endtask
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 7'h1, d[15:8]);
  endtask
  task automatic wake_cs();
    @(posedge sys_clk);
    #1;
    cs_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    cs_n = 1'b1;
  endtask
endmodule

// File: verification/tb_top.sv
// Purpose: Register level tests of scr_regs
// Assumes: Counts shortened by parameters
// Notes: Host model drives the register port
`timescale 1ns/1ps
module tb_top;
  import scr_pkg::*;
  localparam logic [31:0] LOT = 32'h2468_1357; // Arbitrary value
  localparam logic [15:0] PROD = 16'h0c0d; // Arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rst_pin_n;
  scr_req_t req;
  scr_sense_t sense;
  logic cs_n;
  logic [7:0] rdata;
  logic halt, reload, dac_latch, cal_restore, bias_corr, asleep, flash_busy, chksum_busy, selftest_busy;
  logic lin_comp_en, percussion_en, drdy_en, drdy_active_high, drdy_line_two;
  int error_cnt = 0;
  int num_checks = 0;
  int pulses [4] = '{0, 0, 0, 0};
  int cyc = 0;
  always #4 sys_clk = ~sys_clk;
  scr_regs #(.FLASH_CYCLES(32'h64), .CHKSUM_CYCLES(32'h32), .SELFTEST_CYCLES(32'h32),
    .SLEEP_UNIT_CYCLES(32'h14), .BOOT_CYCLES(32'h8), .LOT_CODE(LOT), .PRODUCT_CODE(PROD),
    .SERIAL_CODE(16'h0ffe)) scr_regs_i (.sys_clk, .rst, .req, .sense, .cs_n, .rst_pin_n, .rdata,
    .halt, .reload, .dac_latch, .cal_restore, .bias_corr, .asleep, .flash_busy, .chksum_busy,
    .selftest_busy, .lin_comp_en, .percussion_en, .drdy_en, .drdy_active_high, .drdy_line_two);
  scr_host scr_host_i (.sys_clk, .rdata, .req, .cs_n);
  always @(posedge sys_clk) begin
    cyc++;
    if (dac_latch === 1'b1) pulses[0]++;
    if (cal_restore === 1'b1) pulses[1]++;
    if (bias_corr === 1'b1) pulses[2]++;
    if (reload === 1'b1 && rst === 1'b0) pulses[3]++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] v;
    scr_host_i.rd16(a, v);
    chk(what, exp, v);
  endtask
  task automatic settle(output int n);
    n = 0;
    while (n < 400 && (n < 4 || (halt | flash_busy | chksum_busy | selftest_busy | asleep) !== 1'b0)) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic doze();
    scr_host_i.wr8(7'h3f, 8'h01);
    repeat (20) @(posedge sys_clk);
    #1;
    chk("asleep", 16'h1, {15'h0, asleep});
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0] cmds [3] = '{8'h08, 8'h02, 8'h01};
    rst_pin_n = 1'b1;
    sense = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    settle(n);
    rchk("misc", 7'h38, 16'h0006);
    rchk("flash count", 7'h00, 16'h0000);
    rchk("product", 7'h56, PROD);
    rchk("serial", 7'h58, 16'h0ffe);
    rchk("unmapped", 7'h50, 16'h0000);
    scr_host_i.rd16(7'h52, a);
    scr_host_i.rd16(7'h54, b);
    chk("lot", 16'h1, 16'({b, a} === LOT || {a, b} === LOT));
    $display("Identity test done");
    scr_host_i.wr16(7'h38, 16'h03c3);
    rchk("misc", 7'h38, 16'h00c3);
    chk("misc pins", 16'h1b, {11'h0, lin_comp_en, percussion_en, drdy_en, drdy_active_high, drdy_line_two});
    for (int i = 0; i < 3; i++) begin
      scr_host_i.wr8(7'h42, cmds[i]);
      settle(n);
      rchk("flash count", 7'h00, 16'(i + 1));
      rchk("command", 7'h42, 16'h0000);
    end
    chk("restore pulses", 16'h1, 16'(pulses[1]));
    chk("bias pulses", 16'h1, 16'(pulses[2]));
    scr_host_i.wr8(7'h42, 8'h04);
    settle(n);
    chk("dac pulses", 16'h1, 16'(pulses[0]));
    rchk("flash count", 7'h00, 16'h0003);
    $display("Command test done");
    sense.axis_fail = 6'h21;
    scr_host_i.wr8(7'h39, 8'h08);
    settle(n);
    chk("checksum time", 16'h1, 16'(n <= 60));
    rchk("misc", 7'h38, 16'h00c3);
    rchk("diag", 7'h40, 16'h0040);
    rchk("diag cleared", 7'h40, 16'h0000);
    scr_host_i.wr8(7'h39, 8'h04);
    settle(n);
    rchk("diag", 7'h40, 16'h8420);
    sense.checksum_ok = 1'b1;
    scr_host_i.wr8(7'h39, 8'h08);
    settle(n);
    rchk("diag", 7'h40, 16'h0000);
    $display("Diagnostic test done");
    scr_host_i.wr16(7'h38, 16'h0006);
    scr_host_i.wr8(7'h42, 8'h80);
    settle(n);
    rchk("misc reload", 7'h38, 16'h00c3);
    chk("reload pulses", 16'h2, 16'(pulses[3]));
    $display("Reset test done");
    doze();
    scr_host_i.wake_cs();
    settle(n);
    chk("cs wake", 16'h0, {15'h0, asleep});
    doze();
    rst_pin_n = 1'b0;
    settle(n);
    rst_pin_n = 1'b1;
    chk("pin wake", 16'h0, {15'h0, asleep});
    scr_host_i.wr8(7'h3e, 8'h03);
    settle(n);
    chk("timed sleep", 16'h1, 16'(n >= 58 && n <= 66));
    $display("Sleep test done");
    summarize();
  end
endmodule
